// file: core/scr_regs.sv
// Purpose: Scaler control, status and task registers on a two-wire serial bus
// Assumes: 20 MHz mclk, bus clock well below a quarter of it
// Notes:   Subaddress auto-increments after each byte, in both directions
// Function
// - Marker bit clears to zero at reset
// - Marker bit echoed into status bit three
// - Soft reset bit low holds scaler idle
// - Soft reset bit high releases scaler path
// - Two-bit select routes one ADC to port
// - Three power-save bits at positions 3,1,0
// - Status register read-only, writes ignored
// - Status bit 7 shows expansion tristate pin
// - Status bit 6 shows image tristate pin
// - Status bit 5 shows FIFO almost filled
// - Status bit 4 shows FIFO overflow
// - Status bit 2 shows formatter rate error
// - Status bit 1 shows scaler input field
// - Status bit 0 shows scaler output field
// - Status sampled live at read time
// - Task sets A and B, same layout
// - Field ID from input or toggling flag
// - Polarity bit sets timing-byte bit 7, flag
// - Skip zero to seven fields before task
`default_nettype none
`include "scr_consts.svh"

module scr_regs
  import scr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h21
)(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       scl_pin,
  input  wire logic       sda_pin_i,
  output logic            sda_pin_o,
  output logic            sda_pin_oe,
  input  wire logic [8:0] adc1_result,
  input  wire logic [8:0] adc2_result,
  input  wire logic [8:0] adc3_result,
  input  wire logic [8:0] adc4_result,
  output logic      [8:0] raw_converter_output_port,
  output logic            scaler_soft_reset_n,
  output logic            power_save_bit3,
  output logic            power_save_bit1,
  output logic            power_save_bit0,
  input  wire logic       expansion_tristate_pin,
  input  wire logic       image_tristate_pin,
  input  wire logic       fifo_almost_filled,
  input  wire logic       fifo_overflow,
  input  wire logic       formatter_error,
  input  wire logic       input_field_id,
  input  wire logic       active_set_b,
  input  wire logic       task_request,
  input  wire logic       field_start,
  output logic            output_field_id,
  output logic            task_flag,
  output logic            sav_bit7,
  output logic            task_go,
  output logic      [2:0] event_handler_mode
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [2:0]        scl_sync_reg, scl_sync_next;
  logic [2:0]        sda_sync_reg, sda_sync_next;
  logic [1:0]        expansion_tristate_pin_sync_reg, expansion_tristate_pin_sync_next;
  logic [1:0]        image_tristate_pin_sync_reg, image_tristate_pin_sync_next;
  scr_i2c_state_type state_reg, state_next;
  logic [3:0]        bit_cnt_reg, bit_cnt_next;
  logic [7:0]        shift_reg, shift_next;
  logic [7:0]        tx_reg, tx_next;
  logic [7:0]        ptr_reg, ptr_next;
  logic              rw_reg, rw_next;
  logic              nack_reg, nack_next;
  logic              oe_reg, oe_next;
  logic [7:0]        ctrl_reg, ctrl_next;
  logic [8:0]        raw_reg, raw_next;
  logic              wr_stb;
  logic              scl_rise, scl_fall, start_det, stop_det;
  logic [7:0]        status_byte;
  logic [7:0]        rd_byte;
  logic              programmed_echo;

  scr_task_if tif_a ();
  scr_task_if tif_b ();

  // ****************************************************************
  // Pin synchronisers and bus conditions
  // ****************************************************************
  // Shift pins through two flops; third stage keeps the old level
  always_comb begin
    scl_sync_next  = {scl_sync_reg[1:0], scl_pin};
    sda_sync_next  = {sda_sync_reg[1:0], sda_pin_i};
    expansion_tristate_pin_sync_next = {expansion_tristate_pin_sync_reg[0], expansion_tristate_pin};
    image_tristate_pin_sync_next = {image_tristate_pin_sync_reg[0], image_tristate_pin};
  end

  // Register the synchronisers, bus idles high
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_sync_reg  <= `SCR_SYNC_IDLE;
      sda_sync_reg  <= `SCR_SYNC_IDLE;
      expansion_tristate_pin_sync_reg <= 2'h0;
      image_tristate_pin_sync_reg <= 2'h0;
    end else if (ce) begin
      scl_sync_reg  <= scl_sync_next;
      sda_sync_reg  <= sda_sync_next;
      expansion_tristate_pin_sync_reg <= expansion_tristate_pin_sync_next;
      image_tristate_pin_sync_reg <= image_tristate_pin_sync_next;
    end
  end

  // Edges and start/stop from the second and third stages only
  assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
  assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
  assign start_det = scl_sync_reg[1] & scl_sync_reg[2] &
                     ~sda_sync_reg[1] & sda_sync_reg[2];
  assign stop_det  = scl_sync_reg[1] & scl_sync_reg[2] &
                     sda_sync_reg[1] & ~sda_sync_reg[2];

  // ****************************************************************
  // Status byte and read data
  // ****************************************************************
  // Marker echo straight from the control register
  assign programmed_echo = ctrl_reg[`SCR_CTRL_MARK];
  // Live levels, no capture, read when the byte is loaded
  assign status_byte = {expansion_tristate_pin_sync_reg[1], image_tristate_pin_sync_reg[1],
                        fifo_almost_filled, fifo_overflow,
                        programmed_echo, formatter_error,
                        input_field_id, output_field_id};

  // Read mux over the subaddress pointer; unmapped reads as zero
  always_comb begin
    if (ptr_reg == `SCR_SUB_CTRL) rd_byte = ctrl_reg;
    else if (ptr_reg == `SCR_SUB_STAT) rd_byte = status_byte;
    else if (ptr_reg == `SCR_SUB_TASK_A) rd_byte = tif_a.cfg;
    else if (ptr_reg == `SCR_SUB_TASK_B) rd_byte = tif_b.cfg;
    else rd_byte = 8'h00;
  end

  // ****************************************************************
  // Serial bus slave
  // ****************************************************************
  // Next state of the slave; start and stop win over bit traffic
  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    tx_next      = tx_reg;
    ptr_next     = ptr_reg;
    rw_next      = rw_reg;
    nack_next    = nack_reg;
    oe_next      = oe_reg;
    wr_stb       = 1'b0;
    if (start_det) begin
      state_next   = st_addr;
      bit_cnt_next = 4'h0;
      oe_next      = 1'b0;
    end else if (stop_det) begin
      state_next = st_idle;
      oe_next    = 1'b0;
    end else if (scl_rise) begin
      case (state_reg)
        st_addr, st_sub, st_wdat: begin
          shift_next   = {shift_reg[6:0], sda_sync_reg[1]};
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end
        st_rdat: bit_cnt_next = bit_cnt_reg + 4'h1;
        st_rack: nack_next = sda_sync_reg[1];
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_reg)
        st_addr: begin
          if (bit_cnt_reg == `SCR_BIT_LAST) begin
            if (shift_reg[7:1] == DEV_ADDR) begin
              rw_next    = shift_reg[0];
              oe_next    = 1'b1;
              state_next = st_aack;
            end else begin
              state_next = st_idle;
            end
          end
        end
        st_aack: begin
          bit_cnt_next = 4'h0;
          if (rw_reg) begin
            tx_next    = rd_byte;
            oe_next    = ~rd_byte[7];
            state_next = st_rdat;
          end else begin
            oe_next    = 1'b0;
            state_next = st_sub;
          end
        end
        st_sub: begin
          if (bit_cnt_reg == `SCR_BIT_LAST) begin
            ptr_next   = shift_reg;
            oe_next    = 1'b1;
            state_next = st_sack;
          end
        end
        st_sack, st_wack: begin
          if (state_reg == st_wack) begin
            ptr_next = ptr_reg + 8'h01;
          end
          oe_next      = 1'b0;
          bit_cnt_next = 4'h0;
          state_next   = st_wdat;
        end
        st_wdat: begin
          if (bit_cnt_reg == `SCR_BIT_LAST) begin
            wr_stb     = 1'b1;
            oe_next    = 1'b1;
            state_next = st_wack;
          end
        end
        st_rdat: begin
          if (bit_cnt_reg == `SCR_BIT_LAST) begin
            oe_next    = 1'b0;
            ptr_next   = ptr_reg + 8'h01;
            state_next = st_rack;
          end else begin
            tx_next = {tx_reg[6:0], 1'b0};
            oe_next = ~tx_reg[6];
          end
        end
        st_rack: begin
          if (nack_reg) begin
            state_next = st_idle;
          end else begin
            bit_cnt_next = 4'h0;
            tx_next      = rd_byte;
            oe_next      = ~rd_byte[7];
            state_next   = st_rdat;
          end
        end
        default: ;
      endcase
    end
  end

  // Register the slave
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg   <= st_idle;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      ptr_reg     <= 8'h00;
      rw_reg      <= 1'b0;
      nack_reg    <= 1'b0;
      oe_reg      <= 1'b0;
    end else if (ce) begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      tx_reg      <= tx_next;
      ptr_reg     <= ptr_next;
      rw_reg      <= rw_next;
      nack_reg    <= nack_next;
      oe_reg      <= oe_next;
    end
  end

  // Open-drain data pin: only ever pulls low
  assign sda_pin_o  = 1'b0;
  assign sda_pin_oe = oe_reg;

  // ****************************************************************
  // Global control register and raw converter port
  // ****************************************************************
  // Write decode; only the control subaddress loads it, status takes no write
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_stb && ptr_reg == `SCR_SUB_CTRL) begin
      ctrl_next = shift_reg & `SCR_CTRL_WMASK;
    end
  end

  // Select one converter for the raw port
  always_comb begin
    case (ctrl_reg[`SCR_CTRL_SEL_HI:`SCR_CTRL_SEL_LO])
      2'h0:    raw_next = adc1_result;
      2'h1:    raw_next = adc2_result;
      2'h2:    raw_next = adc3_result;
      default: raw_next = adc4_result;
    endcase
  end

  // Register control and raw port; marker and soft reset clear here
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg <= `SCR_CTRL_RST;
      raw_reg  <= 9'h000;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      raw_reg  <= raw_next;
    end
  end

  assign raw_converter_output_port = raw_reg;
  assign scaler_soft_reset_n = ctrl_reg[`SCR_CTRL_SRST];
  assign power_save_bit3     = ctrl_reg[`SCR_CTRL_PS3];
  assign power_save_bit1     = ctrl_reg[`SCR_CTRL_PS1];
  assign power_save_bit0     = ctrl_reg[`SCR_CTRL_PS0];

  // ****************************************************************
  // Task register sets A and B
  // ****************************************************************
  // Writes by subaddress; the active set alone sees task requests
  assign tif_a.wr_stb         = wr_stb && (ptr_reg == `SCR_SUB_TASK_A);
  assign tif_b.wr_stb         = wr_stb && (ptr_reg == `SCR_SUB_TASK_B);
  assign tif_a.wr_data        = shift_reg;
  assign tif_b.wr_data        = shift_reg;
  assign tif_a.scaler_run     = scaler_soft_reset_n;
  assign tif_b.scaler_run     = scaler_soft_reset_n;
  assign tif_a.task_request   = task_request & ~active_set_b;
  assign tif_b.task_request   = task_request & active_set_b;
  assign tif_a.field_start    = field_start;
  assign tif_b.field_start    = field_start;
  assign tif_a.input_field_id = input_field_id;
  assign tif_b.input_field_id = input_field_id;

  scr_task_set u_set_a (.mclk (mclk), .rst_n (rst_n), .ce (ce), .t (tif_a));
  scr_task_set u_set_b (.mclk (mclk), .rst_n (rst_n), .ce (ce), .t (tif_b));
  // Outputs follow the active set, except task_go, which is the OR of both sets
  assign output_field_id = active_set_b ? tif_b.output_field_id : tif_a.output_field_id;
  assign task_flag       = active_set_b ? tif_b.task_flag : tif_a.task_flag;
  assign sav_bit7        = active_set_b ? tif_b.sav_bit7 : tif_a.sav_bit7;
  assign task_go         = tif_a.task_go | tif_b.task_go;
  assign event_handler_mode = active_set_b ?
                              tif_b.cfg[`SCR_TASK_EVT_HI:`SCR_TASK_EVT_LO] :
                              tif_a.cfg[`SCR_TASK_EVT_HI:`SCR_TASK_EVT_LO];

endmodule

`default_nettype wire

// file: inc/scr_consts.svh
// Purpose: Constants of the scaler control and status register bank
// Assumes: Included by bare name from the design files, not from the package
// Notes:   Subaddresses, field positions, reset values, the write mask and serial bus constants
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH

// ****************************************************************
// Subaddresses
// ****************************************************************
`define SCR_SUB_CTRL    8'h88
`define SCR_SUB_STAT    8'h8f
`define SCR_SUB_TASK_A  8'h90
`define SCR_SUB_TASK_B  8'hc0

// ****************************************************************
// Global ADC port control fields
// ****************************************************************
`define SCR_CTRL_SEL_HI 7
`define SCR_CTRL_SEL_LO 6
`define SCR_CTRL_SRST   5
`define SCR_CTRL_MARK   4
`define SCR_CTRL_PS3    3
`define SCR_CTRL_PS1    1
`define SCR_CTRL_PS0    0
`define SCR_CTRL_RST    8'h00
`define SCR_CTRL_WMASK  8'hfb

// ****************************************************************
// Task handling fields
// ****************************************************************
`define SCR_TASK_POL    7
`define SCR_TASK_FIDSRC 6
`define SCR_TASK_SKP_HI 5
`define SCR_TASK_SKP_LO 3
`define SCR_TASK_EVT_HI 2
`define SCR_TASK_EVT_LO 0
`define SCR_TASK_RST    8'h00

// ****************************************************************
// Serial bus
// ****************************************************************
`define SCR_BIT_LAST    4'h8
`define SCR_SYNC_IDLE   3'h7

`endif

// file: inc/scr_pkg.sv
// Purpose: Types of the scaler control and status register bank
// Assumes: Nothing beyond the constants header
// Notes:   One-hot serial bus slave states
`default_nettype none

package scr_pkg;

  // ****************************************************************
  // Serial bus slave states
  // ****************************************************************
  typedef enum logic [8:0] {
    st_idle = 9'h001,
    st_addr = 9'h002,
    st_aack = 9'h004,
    st_sub  = 9'h008,
    st_sack = 9'h010,
    st_wdat = 9'h020,
    st_wack = 9'h040,
    st_rdat = 9'h080,
    st_rack = 9'h100
  } scr_i2c_state_type;

endpackage

`default_nettype wire

// file: inc/scr_task_if.sv
// Purpose: Link between the register bank and one task register set
// Assumes: Single clock domain, mclk
// Notes:   ctrl side is the register bank, task side the set itself
`default_nettype none

interface scr_task_if;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic [7:0] cfg;
  logic       scaler_run;
  logic       task_request;
  logic       field_start;
  logic       input_field_id;
  logic       output_field_id;
  logic       task_flag;
  logic       sav_bit7;
  logic       task_go;

  modport ctrl (
    output wr_stb, wr_data, scaler_run, task_request, field_start, input_field_id,
    input  cfg, output_field_id, task_flag, sav_bit7, task_go
  );
  modport task_side (
    input  wr_stb, wr_data, scaler_run, task_request, field_start, input_field_id,
    output cfg, output_field_id, task_flag, sav_bit7, task_go
  );
endinterface

`default_nettype wire

// file: core/scr_task_set.sv
// Purpose: One task handling register set with field skip and task flag
// Assumes: Strobes arrive from logic on mclk
// Notes:   Instantiated twice, for set A and set B
`default_nettype none
`include "scr_consts.svh"

module scr_task_set
  import scr_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  scr_task_if.task_side t
);

  logic [7:0] cfg_reg,  cfg_next;
  logic       flag_reg, flag_next;
  logic [2:0] skip_reg, skip_next;
  logic       pend_reg, pend_next;
  logic       go_reg,   go_next;
  logic [2:0] skip_cfg;

  assign skip_cfg = cfg_reg[`SCR_TASK_SKP_HI:`SCR_TASK_SKP_LO];

  // ****************************************************************
  // Configuration, skip counter and task flag
  // ****************************************************************
  // Next values of the set
  always_comb begin
    cfg_next  = t.wr_stb ? t.wr_data : cfg_reg;
    flag_next = flag_reg;
    skip_next = skip_reg;
    pend_next = pend_reg;
    go_next   = 1'b0;
    if (!t.scaler_run) begin                // Idle while scaler held
      flag_next = 1'b0;
      skip_next = 3'h0;
      pend_next = 1'b0;
    end else if (t.task_request) begin
      if (skip_cfg == 3'h0) begin           // Direct execution
        go_next   = 1'b1;
        flag_next = ~flag_reg;              // Toggle per activation
      end else begin
        pend_next = 1'b1;
        skip_next = skip_cfg;               // Fields to skip
      end
    end else if (pend_reg && t.field_start) begin
      if (skip_reg == 3'h1) begin
        pend_next = 1'b0;
        skip_next = 3'h0;
        go_next   = 1'b1;
        flag_next = ~flag_reg;
      end else begin
        skip_next = skip_reg - 3'h1;
      end
    end
  end

  // Register the set
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_reg  <= `SCR_TASK_RST;
      flag_reg <= 1'b0;
      skip_reg <= 3'h0;
      pend_reg <= 1'b0;
      go_reg   <= 1'b0;
    end else if (ce) begin
      cfg_reg  <= cfg_next;
      flag_reg <= flag_next;
      skip_reg <= skip_next;
      pend_reg <= pend_next;
      go_reg   <= go_next;
    end
  end

  // Outputs with polarity and field ID source applied
  assign t.cfg       = cfg_reg;
  assign t.task_go   = go_reg;
  assign t.task_flag = flag_reg ^ cfg_reg[`SCR_TASK_POL];
  assign t.sav_bit7  = ~cfg_reg[`SCR_TASK_POL];
  assign t.output_field_id = cfg_reg[`SCR_TASK_FIDSRC] ?
                             (flag_reg ^ cfg_reg[`SCR_TASK_POL]) :
                             t.input_field_id;

endmodule

`default_nettype wire

// file: dv/scr_regs_asserts.sv
// Purpose: Port-level checks of the scaler register bank
// Assumes: Bound to every scr_regs instance
// Notes:   Sees the top module's ports only
`default_nettype none

module scr_regs_chk (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       ce,
  input wire logic       scl_pin,
  input wire logic       sda_pin_oe,
  input wire logic [8:0] adc1_result,
  input wire logic [8:0] adc2_result,
  input wire logic [8:0] adc3_result,
  input wire logic [8:0] adc4_result,
  input wire logic [8:0] raw_converter_output_port,
  input wire logic       scaler_soft_reset_n,
  input wire logic       power_save_bit3,
  input wire logic       power_save_bit1,
  input wire logic       power_save_bit0,
  input wire logic       input_field_id,
  input wire logic       active_set_b,
  input wire logic       task_request,
  input wire logic       field_start,
  input wire logic       output_field_id,
  input wire logic       task_flag,
  input wire logic       sav_bit7,
  input wire logic       task_go
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ********
  // Assertions
  // ********
  a_reset_clears: assert property (disable iff (1'b0) ce && !rst_n |=>
    !scaler_soft_reset_n && !power_save_bit3 && !power_save_bit1 && !power_save_bit0
    && !task_go && !sda_pin_oe) else $error("outputs not cleared by reset");
  a_raw_select: assert property (ce && rst_n |=>
    raw_converter_output_port == $past(adc1_result) || raw_converter_output_port ==
    $past(adc2_result) || raw_converter_output_port == $past(adc3_result) ||
    raw_converter_output_port == $past(adc4_result)) else $error("raw port not an ADC");
  a_idle_no_task: assert property (ce && !scaler_soft_reset_n |=> !task_go)
    else $error("task ran while scaler idle");
  a_idle_flag: assert property (ce && !scaler_soft_reset_n |=> task_flag == !sav_bit7)
    else $error("flag not cleared while idle");
  a_go_cause: assert property (ce && !task_request && !field_start |=> !task_go)
    else $error("task started without cause");
  a_flag_toggle: assert property (task_go && $past(ce) && $stable(active_set_b) |->
    task_flag != $past(task_flag)) else $error("flag did not toggle on task");
  a_fid_source: assert property (output_field_id == input_field_id ||
    output_field_id == task_flag) else $error("field id from no source");
  a_ctrl_on_fall: assert property ($changed({scaler_soft_reset_n, power_save_bit3,
    power_save_bit1, power_save_bit0}) |-> !scl_pin) else $error("control moved in bit");

  // Main scenarios
  c_task: cover property (task_go);
  c_idle_req: cover property (!scaler_soft_reset_n && task_request);
  c_ack: cover property ($rose(sda_pin_oe));
endmodule

bind scr_regs scr_regs_chk i_scr_regs_chk (.mclk, .rst_n, .ce, .scl_pin, .sda_pin_oe,
  .adc1_result, .adc2_result, .adc3_result, .adc4_result, .raw_converter_output_port,
  .scaler_soft_reset_n, .power_save_bit3, .power_save_bit1, .power_save_bit0,
  .input_field_id, .active_set_b, .task_request, .field_start, .output_field_id,
  .task_flag, .sav_bit7, .task_go);

`default_nettype wire

// file: dv/tb_scr_regs.sv
// Purpose: Self-checking bench of the scaler register bank
// Assumes: Bench is the serial bus master, SDA pulled up
// Notes:   Each SCL phase lasts four mclk
`default_nettype none

module tb_scr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Signals
  // ********
  logic        mclk        = 1'b0;
  logic        rst_n       = 1'b0;
  logic        scl         = 1'b1;
  logic        sda_m       = 1'b1;
  wire         sda_w;
  logic        sda_oe, sda_o;
  logic        ce          = 1'b1;
  logic [8:0]  adc_v [4]   = '{9'h1a5, 9'h05a, 9'h133, 9'h0cc};
  logic [8:0]  raw;
  logic [5:0]  pins        = 6'h00;
  logic        set_b       = 1'b0;
  logic        t_req       = 1'b0;
  logic        f_st        = 1'b0;
  logic        sr_n, ps3, ps1, ps0, fid_o, tflag, sav7, go;
  logic [2:0]  mode;
  logic [7:0]  q;
  logic [15:0] rows [4]    = '{16'h0000, 16'h7470, 16'hbbbb, 16'hfffb};
  int          miscompares = 0;
  int          n_tests     = 0;

  // Open-drain wire with pull-up
  assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
  // Clock
  always #25 mclk = ~mclk;

  scr_regs i_scr_regs (.mclk, .rst_n, .ce, .scl_pin(scl), .sda_pin_i(sda_w),
    .sda_pin_o(sda_o), .sda_pin_oe(sda_oe), .adc1_result(adc_v[0]), .adc2_result(adc_v[1]),
    .adc3_result(adc_v[2]), .adc4_result(adc_v[3]), .raw_converter_output_port(raw),
    .scaler_soft_reset_n(sr_n), .power_save_bit3(ps3), .power_save_bit1(ps1),
    .power_save_bit0(ps0), .expansion_tristate_pin(pins[5]), .image_tristate_pin(pins[4]),
    .fifo_almost_filled(pins[3]), .fifo_overflow(pins[2]), .formatter_error(pins[1]),
    .input_field_id(pins[0]), .active_set_b(set_b), .task_request(t_req),
    .field_start(f_st), .output_field_id(fid_o), .task_flag(tflag), .sav_bit7(sav7),
    .task_go(go), .event_handler_mode(mode));

  // ********
  // Tasks
  // ********
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // Four bus phases, one line changing per phase; level read in the high half
  task automatic ph(input logic [3:0] d, input logic [3:0] c, output logic r);
    for (int i = 3; i >= 0; i--) begin
      sda_m <= d[i];
      scl   <= c[i];
      tk(4);
      if (i == 1) r = sda_w;
    end
  endtask
  // Byte out MSB first, then released acknowledge bit; r holds {data, ack}
  task automatic byt(input logic [7:0] d, output logic [8:0] r);
    for (int i = 7; i >= 0; i--) ph({4{d[i]}}, 4'b0110, r[i+1]);
    ph(4'b1111, 4'b0110, r[0]);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [8:0] r;
    logic       x;
    ph(4'b1100, 4'b0110, x);
    byt(8'h42, r);
    byt(a, r);
    byt(v, r);
    chk({8'h0, r[0]}, 9'h0, "write ack");
    ph(4'b0011, 4'b0111, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [8:0] r;
    logic       x;
    ph(4'b1100, 4'b0110, x);
    byt(8'h42, r);
    byt(a, r);
    ph(4'b1100, 4'b0110, x);
    byt(8'h43, r);
    chk({8'h0, r[0]}, 9'h0, "read ack");
    byt(8'hff, r);
    v = r[8:1];
    ph(4'b0011, 4'b0111, x);
  endtask
  // One request or field pulse, then look for a task start
  task automatic fire(input logic fs, input logic exp, input string m);
    logic s;
    s = 1'b0;
    if (fs) f_st <= 1'b1;
    else t_req <= 1'b1;
    tk(1);
    f_st  <= 1'b0;
    t_req <= 1'b0;
    repeat (3) begin
      tk(1);
      if (go === 1'b1) s = 1'b1;
    end
    chk({8'h0, s}, {8'h0, exp}, m);
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    logic [7:0] w;
    logic [7:0] e;
    tk(5);
    rst_n <= 1'b1;
    tk(4);
    foreach (rows[k]) begin
      w = rows[k][15:8];
      wr(8'h88, w);
      tk(2);
      chk(raw, adc_v[w[7:6]], "adc routing");
      chk({5'h0, sr_n, ps3, ps1, ps0}, {5'h0, w[5], w[3], w[1], w[0]}, "ctrl pins");
      rd(8'h88, q);
      chk({1'b0, q}, {1'b0, rows[k][7:0]}, "ctrl readback");
      rd(8'h8f, q);
      chk({8'h0, q[3]}, {8'h0, w[4]}, "marker echo");
    end
    for (int p = 0; p < 2; p++) begin
      pins <= p ? 6'h15 : 6'h2a;
      tk(4);
      e = {pins[5:2], 1'b1, pins[1:0], pins[0]};
      rd(8'h8f, q);
      chk({1'b0, q}, {1'b0, e}, "status");
      wr(8'h8f, 8'h00);
      rd(8'h8f, q);
      chk({1'b0, q}, {1'b0, e}, "status after write");
    end
    rd(8'h20, q);
    chk({1'b0, q}, 9'h0, "unmapped");
    wr(8'h90, 8'h50);
    chk({8'h0, sav7}, 9'h1, "timing bit default");
    fire(1'b0, 1'b0, "pending task");
    fire(1'b1, 1'b0, "first skip");
    fire(1'b1, 1'b1, "second skip");
    chk({7'h0, tflag, fid_o}, 9'h3, "flag as field id");
    wr(8'hc0, 8'h85);
    set_b <= 1'b1;
    tk(2);
    chk({5'h0, sav7, mode}, 9'h5, "set b config");
    fire(1'b0, 1'b1, "direct task");
    chk({7'h0, tflag, fid_o}, {7'h0, 1'b0, pins[0]}, "set b flag");
    rd(8'h90, q);
    chk({1'b0, q}, 9'h050, "set a readback");
    rd(8'hc0, q);
    chk({1'b0, q}, 9'h085, "set b readback");
    wr(8'h88, 8'h00);
    fire(1'b0, 1'b0, "idle scaler");
    chk({8'h0, tflag}, 9'h1, "flag cleared");
    wr(8'h88, 8'h20);
    fire(1'b0, 1'b1, "released scaler");
    ce <= 1'b0;
    fire(1'b0, 1'b0, "frozen by enable");
    ce <= 1'b1;
    rst_n <= 1'b0;
    tk(5);
    rst_n <= 1'b1;
    tk(4);
    chk({4'h0, sr_n, ps3, ps1, ps0, go}, 9'h0, "reset outputs");
    chk(raw, adc_v[0], "reset select");
    rd(8'h8f, q);
    chk({8'h0, q[3]}, 9'h0, "marker after reset");
    rd(8'hc0, q);
    chk({1'b0, q}, 9'h0, "set b after reset");
    final_report();
  end

  // Watchdog cuts a hang short
  initial begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    final_report();
  end
endmodule

`default_nettype wire
